/* File: hw/reset_mode_sequencer.v */
// Chip operating-mode and reset sequencer
`timescale 1ns/10ps
`include "reset_mode_sequencer_map.vh"
module reset_mode_sequencer #(
  parameter CNT_W    = `PULSE_CNT_W,
  parameter LONG_CYC = `PROG_PULSE_CYC
) (
  // Clock and reset
  input  wire                clk_i,
  input  wire                reset_n_i,
  // Reset pin and supply monitors
  input  wire                ext_reset_n_i,
  input  wire                power_good_i,
  input  wire                brownout_i,
  // Software requests
  input  wire                sw_reset_i,
  input  wire                sleep_req_i,
  input  wire                wake_i,
  input  wire                arm_prog_set_i,
  input  wire                arm_prog_clr_i,
  input  wire                auto_prog_req_i,
  input  wire                ext_nvm_req_i,
  // Programming interface
  input  wire                prog_cmd_valid_i,
  input  wire [2:0]          prog_cmd_port_i,
  input  wire                prog_done_i,
  // Pad configuration in sleep
  input  wire                sleep_pullup_i,
  // Mode outputs
  output reg  [`MODE_W-1:0]  mode_o,
  output reg                 cpu_reset_o,
  output reg                 cpu_run_o,
  output reg                 pad_pullup_o,
  output reg  [2:0]          listen_ports_o,
  output reg                 prog_granted_o,
  output reg                 flash_info_en_o,
  output reg                 ext_nvm_spi_o,
  output reg                 wakeup_timer_en_o,
  output reg                 retention_en_o,
  output reg                 arm_prog_o
);
  // ****************************************************************
  // Reset pulse measurement
  // ****************************************************************
  wire held;
  wire long_held;
  wire release_p;
  wire release_long;

  reset_pulse_timer #(
    .CNT_W    (CNT_W),
    .LONG_CYC (LONG_CYC)
  ) u_timer (
    .clk_i          (clk_i),
    .reset_n_i      (reset_n_i),
    .ext_reset_n_i  (ext_reset_n_i),
    .held_o         (held),
    .long_o         (long_held),
    .release_o      (release_p),
    .release_long_o (release_long)
  );

  // ****************************************************************
  // Mode state machine
  // ****************************************************************
  reg [`MODE_W-1:0] mode_r;
  reg [`MODE_W-1:0] mode_nxt;
  reg               arm_r;
  reg               arm_nxt;
  reg               via_arm_r;
  reg               via_arm_nxt;
  reg               cmd_ok_r;
  reg               cmd_ok_nxt;
  reg [2:0]         listen;

  // A failing supply overrides every mode, sleep and programming included
  wire supply_bad = ~power_good_i | brownout_i;

  always @* begin
    mode_nxt    = mode_r;
    arm_nxt     = arm_r;
    via_arm_nxt = via_arm_r;
    cmd_ok_nxt  = cmd_ok_r;
    if (arm_prog_set_i)
      arm_nxt = 1'b1;
    else if (arm_prog_clr_i)
      arm_nxt = 1'b0;
    // Pin low restarts the chip, except while an external-memory
    // session owns the pin
    if (supply_bad) begin
      mode_nxt   = `MODE_RESET;
      cmd_ok_nxt = 1'b0;
    end else if (held && mode_r != `MODE_PROG_EXTNVM) begin
      mode_nxt   = `MODE_RESET;
      cmd_ok_nxt = 1'b0;
    end else begin
      case (mode_r)
        `MODE_RESET: begin
          if (release_long) begin
            mode_nxt    = `MODE_PROG_RESET;
            via_arm_nxt = 1'b0;
          end else if (arm_r) begin
            // Flag is spent here, so the reset after this session runs code
            mode_nxt    = `MODE_PROG_RESET;
            via_arm_nxt = 1'b1;
            arm_nxt     = 1'b0;
          end else if (!held) begin
            mode_nxt    = `MODE_ACTIVE;
          end
        end
        `MODE_ACTIVE: begin
          if (sw_reset_i)
            mode_nxt = `MODE_RESET;
          else if (auto_prog_req_i)
            mode_nxt = `MODE_PROG_AUTO;
          else if (sleep_req_i)
            mode_nxt = `MODE_SLEEP;
        end
        `MODE_SLEEP: begin
          if (wake_i)
            mode_nxt = `MODE_ACTIVE;
        end
        `MODE_PROG_RESET: begin
          if (!cmd_ok_r && prog_cmd_valid_i &&
              |(prog_cmd_port_i & listen))
            cmd_ok_nxt = 1'b1;
          if (cmd_ok_r && ext_nvm_req_i)
            mode_nxt = `MODE_PROG_EXTNVM;
          else if (cmd_ok_r && prog_done_i) begin
            mode_nxt   = `MODE_RESET;
            cmd_ok_nxt = 1'b0;
          end
        end
        `MODE_PROG_AUTO: begin
          cmd_ok_nxt = 1'b1;
          if (prog_done_i) begin
            mode_nxt   = `MODE_RESET;
            cmd_ok_nxt = 1'b0;
          end
        end
        `MODE_PROG_EXTNVM: begin
          // Programmer keeps the pin low; release ends the session
          if (release_p) begin
            mode_nxt   = `MODE_RESET;
            cmd_ok_nxt = 1'b0;
          end
        end
        default: mode_nxt = `MODE_RESET;
      endcase
    end
  end

  // ****************************************************************
  // Ports watched for the initiating command
  // ****************************************************************
  always @* begin
    listen = 3'h0;
    if (mode_r == `MODE_PROG_RESET) begin
      listen[`PORT_UART] = 1'b1;
      listen[`PORT_SPI]  = 1'b1;
      listen[`PORT_USB]  = via_arm_r;
    end else if (mode_r == `MODE_PROG_AUTO) begin
      listen = 3'h7;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_r    <= `MODE_RESET;
      arm_r     <= 1'b0;
      via_arm_r <= 1'b0;
      cmd_ok_r  <= 1'b0;
    end else begin
      mode_r    <= mode_nxt;
      arm_r     <= arm_nxt;
      via_arm_r <= via_arm_nxt;
      cmd_ok_r  <= cmd_ok_nxt;
    end
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  // Outputs follow the next mode so that they change with mode_o
  wire in_prog = (mode_nxt == `MODE_PROG_RESET) ||
                 (mode_nxt == `MODE_PROG_AUTO)  ||
                 (mode_nxt == `MODE_PROG_EXTNVM);

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_o            <= `MODE_RESET;
      cpu_reset_o       <= 1'b1;
      cpu_run_o         <= 1'b0;
      pad_pullup_o      <= 1'b1;
      listen_ports_o    <= 3'h0;
      prog_granted_o    <= 1'b0;
      flash_info_en_o   <= 1'b0;
      ext_nvm_spi_o     <= 1'b0;
      wakeup_timer_en_o <= 1'b0;
      retention_en_o    <= 1'b0;
      arm_prog_o        <= 1'b0;
    end else begin
      mode_o         <= mode_nxt;
      cpu_reset_o    <= (mode_nxt == `MODE_RESET) || in_prog;
      cpu_run_o      <= (mode_nxt == `MODE_ACTIVE);
      if (mode_nxt == `MODE_SLEEP)
        pad_pullup_o <= sleep_pullup_i;
      else
        pad_pullup_o <= 1'b1;
      // Ports show only once the mode has held for a cycle
      listen_ports_o  <= (mode_nxt == mode_r) ? listen : 3'h0;
      prog_granted_o  <= cmd_ok_nxt && in_prog;
      flash_info_en_o <= cmd_ok_nxt && in_prog;
      ext_nvm_spi_o   <= (mode_nxt == `MODE_PROG_EXTNVM);
      wakeup_timer_en_o <= (mode_nxt == `MODE_SLEEP);
      retention_en_o    <= (mode_nxt == `MODE_SLEEP);
      arm_prog_o        <= arm_nxt;
    end
  end
endmodule

/* File: hw/reset_mode_sequencer_map.vh */
// Constants of the reset and operating-mode sequencer
//
// Overview of operation
// - Reset pulse up to 4ms gives ordinary reset
// - Reset held 5.2ms requests programming mode
// - Long-reset programming watches UART and SPI for command
// - Software flag makes next reset enter programming
// - USB watched only after software-armed programming entry and in auto programming
// - Pads pulled high except in sleep, user choice
// - Sustained-reset programming halts code, allows UART/SPI
// - External memory programming over SPI, reset held
// - Auto programming mode without reset pin access
// - Sleep entered only from active on request
// - Hold reset at power-up until supply good
// - Brown-out forces reset in every mode
// - Programming mode opens code and info pages
`ifndef RESET_MODE_SEQUENCER_MAP_VH
`define RESET_MODE_SEQUENCER_MAP_VH

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_FREQ_HZ       100000000
`define SHORT_PULSE_US    4000
`define PROG_PULSE_US     5200
// Cycles for a least time, clock rate rounded down to whole MHz
`define PROG_PULSE_CYC    ((`PROG_PULSE_US * (`CLK_FREQ_HZ / 1000000)))
`define SHORT_PULSE_CYC   ((`SHORT_PULSE_US * (`CLK_FREQ_HZ / 1000000)))
`define PULSE_CNT_W       20

// ****************************************************************
// Mode codes
// ****************************************************************
`define MODE_W            3
`define MODE_RESET        3'h0
`define MODE_ACTIVE       3'h1
`define MODE_SLEEP        3'h2
`define MODE_PROG_RESET   3'h3
`define MODE_PROG_AUTO    3'h4
`define MODE_PROG_EXTNVM  3'h5

// ****************************************************************
// Programming source port bits
// ****************************************************************
`define PORT_UART         0
`define PORT_SPI          1
`define PORT_USB          2

`endif

/* File: hw/reset_pulse_timer.v */
// Measures the length of low pulses on the external reset pin
`timescale 1ns/10ps
`include "reset_mode_sequencer_map.vh"
module reset_pulse_timer #(
  parameter CNT_W    = `PULSE_CNT_W,
  parameter LONG_CYC = `PROG_PULSE_CYC
) (
  // Clock and reset
  input  wire clk_i,
  input  wire reset_n_i,
  // Pin
  input  wire ext_reset_n_i,
  // Result
  output reg  held_o,
  output reg  long_o,
  output reg  release_o,
  output reg  release_long_o
);
  reg [CNT_W-1:0] count_r;
  reg             pin_low_r;
  wire            reached = (count_r >= LONG_CYC[CNT_W-1:0]);

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_r        <= {CNT_W{1'b0}};
      pin_low_r      <= 1'b0;
      held_o         <= 1'b0;
      long_o         <= 1'b0;
      release_o      <= 1'b0;
      release_long_o <= 1'b0;
    end else begin
      pin_low_r      <= ~ext_reset_n_i;
      release_o      <= 1'b0;
      release_long_o <= 1'b0;
      if (!ext_reset_n_i) begin
        held_o <= 1'b1;
        if (!reached)
          count_r <= count_r + {{(CNT_W-1){1'b0}}, 1'b1};
        long_o <= reached;
      end else begin
        held_o  <= 1'b0;
        long_o  <= 1'b0;
        count_r <= {CNT_W{1'b0}};
        if (pin_low_r) begin
          release_o      <= 1'b1;
          release_long_o <= reached;
        end
      end
    end
  end
endmodule

/* File: tb/mode_seq_checker.sv */
// Property checker for the reset and mode sequencer
`timescale 1ns/10ps
`include "reset_mode_sequencer_map.vh"
module mode_seq_checker #(
  parameter CNT_W    = `PULSE_CNT_W,
  parameter LONG_CYC = `PROG_PULSE_CYC
) (
  input wire               clk_i,
  input wire               reset_n_i,
  input wire               ext_reset_n_i,
  input wire               power_good_i,
  input wire               brownout_i,
  input wire               sleep_pullup_i,
  input wire [`MODE_W-1:0] mode_o,
  input wire               cpu_reset_o,
  input wire               cpu_run_o,
  input wire               pad_pullup_o,
  input wire               wakeup_timer_en_o,
  input wire               retention_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  wire prog_m = mode_o >= `MODE_PROG_RESET;
  wire slp_m  = mode_o == `MODE_SLEEP;
  AST_RUN: assert property (
    mode_o == `MODE_ACTIVE |-> cpu_run_o && !cpu_reset_o)
    else $error("cpu not running in active mode");
  AST_NOCODE: assert property (prog_m |-> cpu_reset_o && !cpu_run_o)
    else $error("code runs in a programming mode");
  AST_PULL: assert property (!slp_m |-> pad_pullup_o)
    else $error("pads not pulled high");
  AST_SLEEP_PULL: assert property (
    slp_m && $past(slp_m) |-> pad_pullup_o == $past(sleep_pullup_i))
    else $error("sleep pad state ignores user choice");
  AST_SLEEP_FROM: assert property (
    slp_m && !$past(slp_m) |-> $past(mode_o) == `MODE_ACTIVE)
    else $error("sleep entered from a mode other than active");
  AST_KEEP: assert property (slp_m |-> wakeup_timer_en_o && retention_en_o)
    else $error("wake timer or retention off in sleep");
  AST_BROWN: assert property (brownout_i |-> ##[1:2] !mode_o)
    else $error("brown-out did not force reset");
  AST_POR: assert property (!power_good_i |-> ##[1:2] cpu_reset_o)
    else $error("cpu released with supply low");
  AST_PIN: assert property (
    $fell(ext_reset_n_i) && mode_o != `MODE_PROG_EXTNVM ##1 !ext_reset_n_i
    |-> ##1 mode_o == `MODE_RESET)
    else $error("reset pin low did not reset");
endmodule
bind reset_mode_sequencer mode_seq_checker #(
  .CNT_W(CNT_W), .LONG_CYC(LONG_CYC)) u_chk (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .ext_reset_n_i(ext_reset_n_i),
  .power_good_i(power_good_i), .brownout_i(brownout_i),
  .sleep_pullup_i(sleep_pullup_i), .mode_o(mode_o),
  .cpu_reset_o(cpu_reset_o), .cpu_run_o(cpu_run_o),
  .pad_pullup_o(pad_pullup_o), .wakeup_timer_en_o(wakeup_timer_en_o),
  .retention_en_o(retention_en_o));

/* File: tb/prog_host.sv */
// External programmer model driving the reset pin and commands
`timescale 1ns/10ps
module prog_host (
  input  wire       clk_i,
  output reg        ext_reset_n_o,
  output reg        cmd_valid_o,
  output reg  [2:0] cmd_port_o
);
  initial begin
    ext_reset_n_o = 1'b1;
    cmd_valid_o   = 1'b0;
    cmd_port_o    = 3'h0;
  end
  // Pin low for n cycles, then released
  task hold_reset(input integer n);
    begin
      @(posedge clk_i) ext_reset_n_o <= 1'b0;
      repeat (n) @(posedge clk_i);
      ext_reset_n_o <= 1'b1;
    end
  endtask
  // One-cycle initiating command; port lines scrambled afterwards
  task send_cmd(input [2:0] p);
    begin
      @(posedge clk_i) begin
        cmd_valid_o <= 1'b1;
        cmd_port_o  <= p;
      end
      @(posedge clk_i) begin
        cmd_valid_o <= 1'b0;
        cmd_port_o  <= ~p;
      end
    end
  endtask
endmodule

/* File: tb/testbench.sv */
// Self-checking testbench of the reset and mode sequencer
`timescale 1ns/10ps
`include "reset_mode_sequencer_map.vh"
module testbench;
  reg clk_i = 1'b0, reset_n_i = 1'b0, pg = 1'b1, bo = 1'b0, sp = 1'b1;
  reg [7:0] sw = 8'h00;
  wire rpin, cv, cr, run, pu, gr, fi, wt, ar, nv, rt;
  wire [2:0] cp, lp, md;
  integer miscompares = 0, compares = 0;
  initial forever #5 clk_i = ~clk_i;
  prog_host host (.clk_i(clk_i), .ext_reset_n_o(rpin), .cmd_valid_o(cv),
    .cmd_port_o(cp));
  reset_mode_sequencer #(.LONG_CYC(50)) dut (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .ext_reset_n_i(rpin), .power_good_i(pg),
    .brownout_i(bo), .sw_reset_i(sw[0]), .sleep_req_i(sw[1]), .wake_i(sw[2]),
    .arm_prog_set_i(sw[3]), .arm_prog_clr_i(sw[6]), .auto_prog_req_i(sw[4]),
    .ext_nvm_req_i(sw[7]), .prog_cmd_valid_i(cv), .prog_cmd_port_i(cp),
    .prog_done_i(sw[5]), .sleep_pullup_i(sp), .mode_o(md), .cpu_reset_o(cr),
    .cpu_run_o(run), .pad_pullup_o(pu), .listen_ports_o(lp),
    .prog_granted_o(gr), .flash_info_en_o(fi), .ext_nvm_spi_o(nv),
    .wakeup_timer_en_o(wt), .retention_en_o(rt), .arm_prog_o(ar));
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    begin
      compares++;
      if (s !== e) begin
        miscompares++;
        $display("ERROR %s expected %h seen %h", n, e, s);
      end
    end
  endtask
  task pulse(input integer b);
    begin
      @(posedge clk_i) sw[b] <= 1'b1;
      @(posedge clk_i) sw[b] <= 1'b0;
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
    end
  endtask
  task t_short;
    begin
      host.hold_reset(30);
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      chk("mode", md, `MODE_ACTIVE);
      chk("run", run, 1'b1);
    end
  endtask
  task t_long;
    begin
      host.hold_reset(60);
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      chk("mode", md, `MODE_PROG_RESET);
      chk("listen", lp, 3'h3);
      chk("run", run, 1'b0);
      chk("pullup", pu, 1'b1);
      host.send_cmd(3'h4);
      @(negedge clk_i);
      chk("grant", gr, 1'b0);
      host.send_cmd(3'h2);
      @(posedge clk_i);
      @(negedge clk_i);
      chk("grant", gr, 1'b1);
      chk("info", fi, 1'b1);
      pulse(5);
      chk("mode", md, `MODE_ACTIVE);
    end
  endtask
  task t_nvm;
    begin
      host.hold_reset(60);
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      chk("mode", md, `MODE_PROG_RESET);
      host.send_cmd(3'h1);
      pulse(7);
      chk("mode", md, `MODE_PROG_EXTNVM);
      chk("nvmspi", nv, 1'b1);
      chk("run", run, 1'b0);
      fork
        host.hold_reset(10);
        begin
          repeat (6) @(posedge clk_i);
          @(negedge clk_i);
          chk("mode", md, `MODE_PROG_EXTNVM);
        end
      join
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      chk("mode", md, `MODE_ACTIVE);
      chk("nvmspi", nv, 1'b0);
    end
  endtask
  task t_arm;
    begin
      pulse(3);
      chk("armed", ar, 1'b1);
      pulse(6);
      chk("armed", ar, 1'b0);
      pulse(3);
      pulse(0);
      chk("mode", md, `MODE_PROG_RESET);
      chk("listen", lp, 3'h7);
      chk("cpurst", cr, 1'b1);
      chk("armed", ar, 1'b0);
      host.send_cmd(3'h4);
      @(negedge clk_i);
      chk("grant", gr, 1'b1);
      pulse(5);
      chk("mode", md, `MODE_ACTIVE);
    end
  endtask
  task t_sleep;
    begin
      @(posedge clk_i) sp <= 1'b0;
      pulse(1);
      chk("mode", md, `MODE_SLEEP);
      chk("pullup", pu, 1'b0);
      chk("wut", wt, 1'b1);
      chk("retain", rt, 1'b1);
      pulse(4);
      chk("mode", md, `MODE_SLEEP);
      pulse(2);
      chk("mode", md, `MODE_ACTIVE);
      chk("retain", rt, 1'b0);
      pulse(4);
      chk("mode", md, `MODE_PROG_AUTO);
      chk("listen", lp, 3'h7);
      chk("pullup", pu, 1'b1);
      pulse(5);
      chk("mode", md, `MODE_ACTIVE);
    end
  endtask
  task t_supply;
    begin
      @(posedge clk_i) bo <= 1'b1;
      @(posedge clk_i) bo <= 1'b0;
      @(negedge clk_i);
      chk("mode", md, `MODE_RESET);
      @(posedge clk_i) pg <= 1'b0;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      chk("cpurst", cr, 1'b1);
      chk("run", run, 1'b0);
      @(posedge clk_i) pg <= 1'b1;
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      chk("mode", md, `MODE_ACTIVE);
    end
  endtask
  task complete_run;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    miscompares++;
    complete_run;
  end
  initial begin
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk("mode", md, `MODE_ACTIVE);
    t_short;
    t_long;
    t_nvm;
    t_arm;
    t_sleep;
    t_supply;
    complete_run;
  end
endmodule
